//--- rtl/wdtps_watchdog.sv
`timescale 1ns/1ps
module wdtps_watchdog #(
    // last count before overflow, base divider minus one
    parameter logic [15:0] CNT_MAX     = wdtps_pkg::CNT_MAX,
    parameter logic [7:0]  BASE_DIV_M1 = wdtps_pkg::BASE_DIV_M1
) (
    // clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      rst_b,
    // software control
    input  wire logic                      enable,
    input  wire logic                      refresh_bit,
    input  wire logic                      suspend_en,
    // on-chip debug logic
    input  wire logic                      debug_mode,
    input  wire logic                      monitor_mode,
    // pll divider configuration
    input  wire logic                      div_wr,
    input  wire logic [wdtps_pkg::DIV_W-1:0] div_wdata,
    // status and results
    output logic                           nmi_req,
    output logic                           prewarn,
    output logic                           wdt_reset,
    output logic [wdtps_pkg::CNT_W-1:0]    count,
    output logic [wdtps_pkg::DIV_W-1:0]    pll_feedback_divider
);
    // last prewarning count, one below the period length
    localparam logic [7:0] PRE_LAST = wdtps_pkg::PREWARN_COUNTS - 8'h01;

    wdtps_pkg::wdtps_state_t      state_reg;
    logic [wdtps_pkg::BASE_W-1:0] base_reg;
    logic [7:0]                   pre_reg;
    logic [3:0]                   rst_cnt_reg;
    logic                         suspended;
    logic                         base_wrap;
    logic                         tick;
    logic                         refresh_ok;
    logic                         in_count;
    logic                         in_warn;
    logic                         in_reset;
    logic                         overflow;
    logic                         pre_done;
    logic                         pulse_done;

    // true when a counter stands on its last value
    function automatic logic at_last(input logic [15:0] value,
                                     input logic [15:0] last);
        return value == last;
    endfunction

    assign in_count = (state_reg == wdtps_pkg::WDTPS_COUNT);
    assign in_warn  = (state_reg == wdtps_pkg::WDTPS_PREWARN);
    assign in_reset = (state_reg == wdtps_pkg::WDTPS_RESET);

    // monitor mode always suspends, debug mode only when opted in
    assign suspended = (suspend_en && debug_mode) || monitor_mode;
    assign base_wrap = at_last(16'(base_reg), 16'(BASE_DIV_M1));
    assign tick      = enable && !suspended && base_wrap;

    // refresh writes only count in the count state, not during prewarning or the reset pulse
    assign refresh_ok = refresh_bit && in_count;

    // overflow only on a tick at the top count with no refresh pending
    assign overflow = in_count && !refresh_ok && tick &&
                      at_last(count, CNT_MAX);
    assign pre_done = in_warn && tick &&
                      at_last(16'(pre_reg), 16'(PRE_LAST));
    assign pulse_done = in_reset &&
                        at_last(16'(rst_cnt_reg),
                                16'(wdtps_pkg::RST_PULSE_M1));

    // base prescaler, cleared by any accepted refresh, suspended or not
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            base_reg <= '0;
        end else if (refresh_ok || !enable) begin
            base_reg <= '0;
        end else if (!suspended) begin
            if (base_wrap) begin
                base_reg <= '0;
            end else begin
                base_reg <= base_reg + 1'b1;
            end
        end
    end

    // state sequence: count, prewarning, reset pulse
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= wdtps_pkg::WDTPS_COUNT;
        end else begin
            case (state_reg)
                wdtps_pkg::WDTPS_COUNT: begin
                    if (overflow) begin
                        state_reg <= wdtps_pkg::WDTPS_PREWARN;
                    end
                end
                wdtps_pkg::WDTPS_PREWARN: begin
                    // refresh writes are not looked at here
                    if (pre_done) begin
                        state_reg <= wdtps_pkg::WDTPS_RESET;
                    end
                end
                wdtps_pkg::WDTPS_RESET: begin
                    if (pulse_done) begin
                        state_reg <= wdtps_pkg::WDTPS_COUNT;
                    end
                end
                default: begin
                    state_reg <= wdtps_pkg::WDTPS_COUNT;
                end
            endcase
        end
    end

    // watchdog count; holds at the top value through prewarning
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= wdtps_pkg::CNT_RELOAD;
        end else if (in_count) begin
            if (refresh_ok || !enable) begin
                count <= wdtps_pkg::CNT_RELOAD;
            end else if (tick && !at_last(count, CNT_MAX)) begin
                count <= count + 16'h0001;
            end
        end else if (pulse_done) begin
            count <= wdtps_pkg::CNT_RELOAD;
        end
    end

    // prewarning length in watchdog counts
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_reg <= '0;
        end else if (overflow || pulse_done) begin
            pre_reg <= '0;
        end else if (in_warn && tick && !pre_done) begin
            pre_reg <= pre_reg + 8'h01;
        end
    end

    // length of the watchdog reset pulse
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_cnt_reg <= '0;
        end else if (pre_done) begin
            rst_cnt_reg <= '0;
        end else if (in_reset && !pulse_done) begin
            rst_cnt_reg <= rst_cnt_reg + 4'h1;
        end
    end

    // one-cycle interrupt request at overflow
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            nmi_req <= 1'b0;
        end else begin
            nmi_req <= overflow;
        end
    end

    // prewarning flag, from overflow until the reset pulse starts
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            prewarn <= 1'b0;
        end else if (overflow) begin
            prewarn <= 1'b1;
        end else if (pre_done) begin
            prewarn <= 1'b0;
        end
    end

    // watchdog reset request, a fixed pulse after prewarning
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wdt_reset <= 1'b0;
        end else if (pre_done) begin
            wdt_reset <= 1'b1;
        end else if (pulse_done) begin
            wdt_reset <= 1'b0;
        end
    end

    // divider only reset by rst_b, never by the watchdog reset
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pll_feedback_divider <= wdtps_pkg::DIV_DEFAULT;
        end else if (div_wr && !wdt_reset) begin
            pll_feedback_divider <= div_wdata;
        end
    end
endmodule // wdtps_watchdog

//--- rtl/wdtps_pkg.sv
package wdtps_pkg;
    // watchdog count width and prewarning length in watchdog counts
    localparam int          CNT_W          = 16;
    localparam logic [15:0] CNT_RELOAD     = 16'h0000;
    localparam logic [15:0] CNT_MAX        = 16'hFFFF;
    localparam logic [7:0]  PREWARN_COUNTS = 8'h30;
    // base counter: one watchdog count per BASE_DIV clock cycles
    localparam int          BASE_W         = 8;
    localparam logic [7:0]  BASE_DIV_M1    = 8'hFF;
    // pll feedback divider
    localparam int          DIV_W          = 5;
    localparam logic [4:0]  DIV_DEFAULT    = 5'h18;
    // length of the watchdog reset pulse in clock cycles, minus one
    localparam logic [3:0]  RST_PULSE_M1   = 4'hF;

    typedef enum logic [1:0] {
        WDTPS_COUNT,
        WDTPS_PREWARN,
        WDTPS_RESET
    } wdtps_state_t;
endpackage

//--- testbench/wdtps_sva.sv
`timescale 1ns/1ps
module wdtps_sva #(
    parameter logic [15:0] CNT_MAX     = wdtps_pkg::CNT_MAX,
    parameter logic [7:0]  BASE_DIV_M1 = wdtps_pkg::BASE_DIV_M1
) (
    // watched ports
    input wire logic        ref_clk, rst_b, refresh_bit, suspend_en,
    input wire logic        debug_mode, monitor_mode, nmi_req, prewarn,
    input wire logic        wdt_reset,
    input wire logic [15:0] count,
    input wire logic [4:0]  pll_feedback_divider
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    wire hold = (monitor_mode | (debug_mode & suspend_en)) & ~refresh_bit;
    wire busy = prewarn | wdt_reset;
    logic [15:0] pw_reg;
    localparam logic [15:0] WARN_CYC = 16'(wdtps_pkg::PREWARN_COUNTS) *
                                       (16'(BASE_DIV_M1) + 16'h0001);
    sequence s_enter; nmi_req && prewarn; endsequence
    always_ff @(posedge ref_clk or negedge rst_b)
        if (!rst_b) pw_reg <= 16'h0000;
        else pw_reg <= prewarn ? pw_reg + 16'h0001 : 16'h0000;
    a_suspend_hold: assert property (hold & ~busy |=> $stable(count))
        else $error("count moved while suspended");
    a_refresh_clear: assert property (refresh_bit & ~busy |=> !count)
        else $error("refresh did not clear count");
    a_nmi_pulse: assert property (nmi_req |=> !nmi_req)
        else $error("nmi request longer than one cycle");
    a_nmi_top: assert property (nmi_req |-> count == CNT_MAX)
        else $error("nmi request without overflow");
    a_warn_enter: assert property ($rose(prewarn) |-> s_enter)
        else $error("prewarning entered without nmi");
    a_warn_end: assert property ($fell(prewarn) |-> wdt_reset)
        else $error("prewarning ended without reset");
    a_warn_len: assert property ($fell(prewarn) |->
        pw_reg == WARN_CYC)
        else $error("prewarning length wrong");
    a_reset_clear: assert property ($fell(wdt_reset) |-> count == 16'h0000)
        else $error("count not reloaded after watchdog reset");
    a_warn_refuse: assert property (prewarn & refresh_bit |=> busy)
        else $error("refresh cancelled prewarning");
    a_div_keep: assert property (wdt_reset |=> $stable(pll_feedback_divider))
        else $error("divider changed by watchdog reset");
endmodule // wdtps_sva
bind wdtps_watchdog wdtps_sva #(.CNT_MAX(CNT_MAX),
    .BASE_DIV_M1(BASE_DIV_M1)) u_sva (.ref_clk, .rst_b, .refresh_bit,
    .suspend_en, .debug_mode, .monitor_mode, .nmi_req, .prewarn,
    .wdt_reset, .count, .pll_feedback_divider);

//--- testbench/wdtps_sw_model.sv
`timescale 1ns/1ps
module wdtps_sw_model (
    // software side
    input  wire logic ref_clk,
    input  wire logic want_refresh,
    input  wire logic insist,
    input  wire logic prewarn,
    output logic      refresh_bit = 1'b0
);
    // insist stands for misbehaving software that ignores the advice
    always_ff @(posedge ref_clk)
        refresh_bit <= want_refresh & (~prewarn | insist);
endmodule // wdtps_sw_model

//--- testbench/watchdog_prewarn_suspend_tb_top.sv
`timescale 1ns/1ps
module watchdog_prewarn_suspend_tb_top;
    // shortened interval: 64 counts of 4 cycles each
    localparam logic [15:0] TB_CNT_MAX = 16'h003F;
    localparam logic [7:0]  TB_BASE_M1 = 8'h03;
    logic        ref_clk      = 1'b0;
    logic        rst_b        = 1'b0;
    logic        enable       = 1'b0;
    logic        want         = 1'b0;
    logic        insist       = 1'b0;
    logic        suspend_en   = 1'b0;
    logic        debug_mode   = 1'b0;
    logic        monitor_mode = 1'b0;
    logic        div_wr       = 1'b0;
    logic [4:0]  div_wdata    = 5'h00;
    logic [4:0]  div_exp      = wdtps_pkg::DIV_DEFAULT;
    logic        refresh_bit;
    logic        nmi_req;
    logic        prewarn;
    logic        wdt_reset;
    logic [4:0]  pll_feedback_divider;
    logic [15:0] count;
    logic [23:0] q[$];
    logic [23:0] e;
    logic [23:0] seen;
    logic [31:0] r;
    int          err_count = 0;
    int          n_checks  = 0;
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    wdtps_watchdog #(
        .CNT_MAX     (TB_CNT_MAX),
        .BASE_DIV_M1 (TB_BASE_M1)
    ) dut (.ref_clk, .rst_b, .enable, .refresh_bit, .suspend_en,
        .debug_mode, .monitor_mode, .div_wr, .div_wdata, .nmi_req, .prewarn,
        .wdt_reset, .count, .pll_feedback_divider);
    wdtps_sw_model sw (.ref_clk, .want_refresh(want), .insist, .prewarn,
        .refresh_bit);
    task automatic clk(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // note what must stand after this edge, then move on one cycle
    task automatic expect_now(input logic [15:0] c, input logic [2:0] f);
        q.push_back({c, div_exp, f});
        clk(1);
    endtask
    // refresh through the software model, taken two edges later
    task automatic refresh();
        want <= 1'b1;
        clk(1);
        want <= 1'b0;
        clk(1);
    endtask
    task automatic print_verdict();
        if (err_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(negedge ref_clk) begin
        if (q.size() > 0) begin
            e = q.pop_front();
            seen = {count, pll_feedback_divider, nmi_req, prewarn, wdt_reset};
            n_checks++;
            if (e !== seen) begin
                err_count++;
                $display("mismatch count_div_flags exp %h got %h", e, seen);
            end
        end
    end
    initial begin
        void'($urandom(56643));
        clk(3);
        rst_b  <= 1'b1;
        enable <= 1'b1;
        r = $urandom;
        expect_now(16'h0000, 3'b000);
        div_wdata <= r[4:0];
        div_wr    <= 1'b1;
        clk(1);
        div_wr    <= 1'b0;
        div_exp = r[4:0];
        expect_now(16'h0000, 3'b000);
        for (int i = 0; i < 2; i++) begin
            refresh();
            clk(40);
            expect_now(16'h000A, 3'b000);
            suspend_en   <= (i == 0);
            debug_mode   <= (i == 0);
            monitor_mode <= (i == 1);
            clk(100);
            expect_now(16'h000A, 3'b000);
            refresh();
            expect_now(16'h0000, 3'b000);
            suspend_en   <= 1'b0;
            debug_mode   <= 1'b0;
            monitor_mode <= 1'b0;
            clk(3);
            expect_now(16'h0000, 3'b000);
            expect_now(16'h0001, 3'b000);
        end
        refresh();
        clk(255);
        expect_now(TB_CNT_MAX, 3'b000);
        expect_now(TB_CNT_MAX, 3'b110);
        insist <= 1'b1;
        refresh();
        insist <= 1'b0;
        expect_now(TB_CNT_MAX, 3'b010);
        clk(187);
        expect_now(TB_CNT_MAX, 3'b010);
        expect_now(TB_CNT_MAX, 3'b001);
        div_wdata <= ~r[4:0];
        div_wr    <= 1'b1;
        clk(1);
        div_wr    <= 1'b0;
        clk(13);
        expect_now(TB_CNT_MAX, 3'b001);
        expect_now(16'h0000, 3'b000);
        rst_b <= 1'b0;
        clk(2);
        div_exp = wdtps_pkg::DIV_DEFAULT;
        rst_b <= 1'b1;
        expect_now(16'h0000, 3'b000);
        clk(3);
        print_verdict();
    end
endmodule // watchdog_prewarn_suspend_tb_top
